//--- logic/ucc_charge_ctrl.sv
// charge mode controller: mode decode, auto detection, discharge, hid wake
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none

module ucc_charge_ctrl #(
    parameter int unsigned DISCHARGE_CYCLES  = ucc_pkg::DISCHARGE_CYCLES,
    parameter int unsigned PULLUP_CYCLES     = ucc_pkg::PULLUP_CYCLES,
    parameter int unsigned HC_WINDOW_CYCLES  = ucc_pkg::HC_WINDOW_CYCLES,
    parameter int unsigned FS_QUALIFY_CYCLES = ucc_pkg::FS_QUALIFY_CYCLES
) (
    // clock and resets
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   power_on_reset,
    // ahb-lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    // analog sensing
    input  wire ucc_pkg::ucc_sense_t    sense,
    // switch and signature drive
    output ucc_pkg::ucc_line_ctl_t      line_ctl
);

    // ******************************
    // decode helpers
    // ******************************

    // pins are {mode_select_1, mode_select_2, mode_select_3, current_limit_select}
    function automatic ucc_pkg::ucc_mode_t decode_mode(input logic [3:0] pins);
        ucc_pkg::ucc_mode_t m;
        m = ucc_pkg::M_OFF;
        case (pins[3:1])
            3'h0: m = ucc_pkg::M_OFF;
            3'h1, 3'h3: m = ucc_pkg::M_AUTO;
            3'h2, 3'h6: m = ucc_pkg::M_STD_A;
            3'h4: m = ucc_pkg::M_FORCE_SHORT;
            3'h5: m = ucc_pkg::M_FORCE_DIV;
            default: m = pins[0] ? ucc_pkg::M_CHG_PORT : ucc_pkg::M_STD_B;
        endcase
        return m;
    endfunction : decode_mode

    // first state of a mode
    function automatic ucc_pkg::ucc_state_t entry_state(input ucc_pkg::ucc_mode_t m);
        ucc_pkg::ucc_state_t s;
        s = ucc_pkg::S_OFF;
        case (m)
            ucc_pkg::M_OFF:         s = ucc_pkg::S_OFF;
            ucc_pkg::M_AUTO:        s = ucc_pkg::S_DIV_LOW;
            ucc_pkg::M_STD_A:       s = ucc_pkg::S_STD_PORT;
            ucc_pkg::M_STD_B:       s = ucc_pkg::S_STD_PORT;
            ucc_pkg::M_FORCE_SHORT: s = ucc_pkg::S_FORCE_SHORT;
            ucc_pkg::M_FORCE_DIV:   s = ucc_pkg::S_FORCE_DIV;
            ucc_pkg::M_CHG_PORT:    s = ucc_pkg::S_CHG_PORT;
            default:                s = ucc_pkg::S_OFF;
        endcase
        return s;
    endfunction : entry_state

    function automatic logic is_port_mode(input ucc_pkg::ucc_mode_t m);
        return (m == ucc_pkg::M_STD_A) || (m == ucc_pkg::M_STD_B)
            || (m == ucc_pkg::M_CHG_PORT);
    endfunction : is_port_mode

    // ******************************
    // register bus
    // ******************************
    ucc_pkg::ucc_ctrl_t ctrl;
    ucc_pkg::ucc_ctrl_t next_ctrl;
    logic               wr_pend;
    logic               next_wr_pend;
    logic [31:0]        wr_addr;
    logic [31:0]        next_wr_addr;
    logic [31:0]        next_hrdata;
    logic [31:0]        status_word;
    logic               addr_phase;

    // zero wait states, always okay
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel && htrans[1] && hready;

    // bus next values: writes land in the data phase, reads are fetched early
    always_comb begin
        next_ctrl    = ctrl;
        next_wr_pend = addr_phase && hwrite;
        next_wr_addr = addr_phase ? haddr : wr_addr;
        next_hrdata  = hrdata;
        if (wr_pend && wr_addr == ucc_pkg::ADDR_CTRL) begin
            next_ctrl = hwdata[4:0];
        end
        if (addr_phase && !hwrite) begin
            case (haddr)
                ucc_pkg::ADDR_CTRL:   next_hrdata = {27'h0, ctrl};
                ucc_pkg::ADDR_STATUS: next_hrdata = status_word;
                default:              next_hrdata = 32'h0;   // unmapped reads zero
            endcase
        end
    end

    // bus registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl    <= ucc_pkg::ucc_ctrl_t'(ucc_pkg::CTRL_RESET[4:0]);
            wr_pend <= 1'b0;
            wr_addr <= 32'h0;
            hrdata  <= 32'h0;
        end else begin
            ctrl    <= next_ctrl;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata  <= next_hrdata;
        end
    end

    // ******************************
    // mode request and hid override
    // ******************************
    ucc_pkg::ucc_state_t state;
    ucc_pkg::ucc_state_t next_state;
    ucc_pkg::ucc_state_t target;
    ucc_pkg::ucc_state_t next_target;
    ucc_pkg::ucc_mode_t  cur_mode;
    ucc_pkg::ucc_mode_t  next_cur_mode;
    ucc_pkg::ucc_mode_t  pin_mode;
    ucc_pkg::ucc_mode_t  req_mode;
    logic [31:0]         timer;
    logic [31:0]         next_timer;
    logic                hid_detected;
    logic                override;
    logic                direct_swap;

    assign pin_mode = decode_mode({ctrl.mode_select_1, ctrl.mode_select_2,
                                   ctrl.mode_select_3, ctrl.current_limit_select});

    // port mode held against a move to 011 while an hid is attached
    assign override = hid_detected && is_port_mode(cur_mode)
        && ({ctrl.mode_select_1, ctrl.mode_select_2, ctrl.mode_select_3} == 3'h3);
    assign req_mode = override ? cur_mode : pin_mode;

    // standard port b and charging port change over without discharge
    assign direct_swap = (cur_mode == ucc_pkg::M_STD_B && req_mode == ucc_pkg::M_CHG_PORT)
        || (cur_mode == ucc_pkg::M_CHG_PORT && req_mode == ucc_pkg::M_STD_B);

    // ******************************
    // charge state machine
    // ******************************

    // next state, discharge target and phase timer
    always_comb begin
        next_state    = state;
        next_target   = target;
        next_cur_mode = cur_mode;
        next_timer    = timer + 32'h1;
        if (power_on_reset) begin
            next_state    = ucc_pkg::S_INIT;
            next_cur_mode = ucc_pkg::M_OFF;
            next_timer    = 32'h0;
        end else if (state == ucc_pkg::S_INIT) begin
            next_state    = entry_state(pin_mode);
            next_cur_mode = pin_mode;
            next_timer    = 32'h0;
        end else if (req_mode != cur_mode) begin
            next_cur_mode = req_mode;
            next_timer    = 32'h0;
            if (direct_swap) begin
                next_state = entry_state(req_mode);
            end else if (req_mode == ucc_pkg::M_OFF) begin
                next_state = ucc_pkg::S_OFF;
            end else begin
                next_state  = ucc_pkg::S_DISCH;
                next_target = entry_state(req_mode);
            end
        end else begin
            case (state)
                ucc_pkg::S_DISCH: begin
                    if (timer >= 32'(DISCHARGE_CYCLES - 1)) begin
                        next_state = target;
                        next_timer = 32'h0;
                    end
                end
                ucc_pkg::S_DIV_LOW: begin
                    // a divider device just keeps drawing here
                    if (sense.bc_device_seen) begin
                        next_state  = ucc_pkg::S_DISCH;
                        next_target = ucc_pkg::S_PULLUP;
                        next_timer  = 32'h0;
                    end else if (sense.high_current) begin
                        next_state = ucc_pkg::S_DIV_HIGH;
                        next_timer = 32'h0;
                    end
                end
                ucc_pkg::S_DIV_HIGH: begin
                    if (sense.bc_device_seen) begin
                        next_state  = ucc_pkg::S_DISCH;
                        next_target = ucc_pkg::S_PULLUP;
                        next_timer  = 32'h0;
                    end else if (timer >= 32'(HC_WINDOW_CYCLES - 1)) begin
                        next_timer = 32'h0;
                        if (!sense.high_current) begin
                            next_state = ucc_pkg::S_DIV_LOW;
                        end
                    end
                end
                ucc_pkg::S_PULLUP: begin
                    if (timer >= 32'(PULLUP_CYCLES - 1)) begin
                        next_state = ucc_pkg::S_AUTO_SHORT;
                        next_timer = 32'h0;
                    end
                end
                ucc_pkg::S_AUTO_SHORT: begin
                    if (sense.data_released) begin
                        next_state = ucc_pkg::S_DIV_LOW;
                    end
                    next_timer = 32'h0;
                end
                ucc_pkg::S_OFF, ucc_pkg::S_FORCE_SHORT, ucc_pkg::S_FORCE_DIV,
                ucc_pkg::S_STD_PORT, ucc_pkg::S_CHG_PORT: begin
                    next_timer = 32'h0;
                end
                default: begin
                    next_state = ucc_pkg::S_INIT;
                    next_timer = 32'h0;
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state    <= ucc_pkg::S_INIT;
            target   <= ucc_pkg::S_OFF;
            cur_mode <= ucc_pkg::M_OFF;
            timer    <= 32'h0;
        end else begin
            state    <= next_state;
            target   <= next_target;
            cur_mode <= next_cur_mode;
            timer    <= next_timer;
        end
    end

    // ******************************
    // switch and signature drive
    // ******************************
    ucc_pkg::ucc_line_ctl_t next_line_ctl;

    // outputs follow the state being entered so they line up with it
    always_comb begin
        next_line_ctl.power_switch_on = 1'b1;
        next_line_ctl.discharge_on    = 1'b0;
        next_line_ctl.data_switch_on  = 1'b0;
        next_line_ctl.scheme          = ucc_pkg::SCH_OPEN;
        case (next_state)
            ucc_pkg::S_INIT, ucc_pkg::S_OFF, ucc_pkg::S_DISCH: begin
                next_line_ctl.power_switch_on = 1'b0;
                next_line_ctl.discharge_on    = 1'b1;
                next_line_ctl.data_switch_on  = 1'b0;
            end
            ucc_pkg::S_DIV_LOW, ucc_pkg::S_FORCE_DIV: begin
                next_line_ctl.scheme = ucc_pkg::SCH_DIV_LOW;
            end
            ucc_pkg::S_DIV_HIGH: begin
                next_line_ctl.scheme = ucc_pkg::SCH_DIV_HIGH;
            end
            ucc_pkg::S_PULLUP: begin
                next_line_ctl.scheme = ucc_pkg::SCH_PULLUP;
            end
            ucc_pkg::S_AUTO_SHORT, ucc_pkg::S_FORCE_SHORT: begin
                next_line_ctl.scheme = ucc_pkg::SCH_SHORT;
            end
            ucc_pkg::S_STD_PORT, ucc_pkg::S_CHG_PORT: begin
                // current limiting does not reach this term
                next_line_ctl.data_switch_on = ctrl.enable;
            end
            default: begin
                next_line_ctl.power_switch_on = 1'b0;
                next_line_ctl.discharge_on    = 1'b1;
            end
        endcase
    end

    // registered drive, discharging from reset
    always_ff @(posedge clk) begin
        if (reset) begin
            line_ctl <= '{power_switch_on: 1'b0, discharge_on: 1'b1,
                          data_switch_on: 1'b0, scheme: ucc_pkg::SCH_OPEN};
        end else begin
            line_ctl <= next_line_ctl;
        end
    end

    // ******************************
    // hid attach recognition
    // ******************************
    logic        ls_hid;
    logic        fs_hid;
    logic        fs_cand;
    logic        hs_seen;
    logic [31:0] fs_count;
    logic        next_ls_hid;
    logic        next_fs_hid;
    logic        next_fs_cand;
    logic        next_hs_seen;
    logic [31:0] next_fs_count;
    logic        monitor;

    assign monitor      = (state == ucc_pkg::S_STD_PORT) || (state == ucc_pkg::S_CHG_PORT);
    assign hid_detected = ls_hid || fs_hid;

    // attach speed from idle line levels
    always_comb begin
        next_ls_hid   = ls_hid;
        next_fs_hid   = fs_hid;
        next_fs_cand  = fs_cand;
        next_hs_seen  = hs_seen;
        next_fs_count = fs_count;
        if (!monitor || power_on_reset) begin
            next_ls_hid   = 1'b0;
            next_fs_hid   = 1'b0;
            next_fs_cand  = 1'b0;
            next_hs_seen  = 1'b0;
            next_fs_count = 32'h0;
        end else if (sense.dm_high && !sense.dp_high) begin
            next_ls_hid = 1'b1;
        end else if (sense.dp_high && !sense.dm_high) begin
            if (!hs_seen) begin
                next_fs_cand = 1'b1;
                if (fs_count >= 32'(FS_QUALIFY_CYCLES - 1)) begin
                    next_fs_hid = 1'b1;
                end else begin
                    next_fs_count = fs_count + 32'h1;
                end
            end
        end else if (!sense.dp_high && !sense.dm_high) begin
            // D+ released after connect means a high speed device
            next_hs_seen  = hs_seen || (fs_cand && !fs_hid);
            next_ls_hid   = 1'b0;
            next_fs_hid   = 1'b0;
            next_fs_cand  = 1'b0;
            next_fs_count = 32'h0;
        end
    end

    // hid registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ls_hid   <= 1'b0;
            fs_hid   <= 1'b0;
            fs_cand  <= 1'b0;
            hs_seen  <= 1'b0;
            fs_count <= 32'h0;
        end else begin
            ls_hid   <= next_ls_hid;
            fs_hid   <= next_fs_hid;
            fs_cand  <= next_fs_cand;
            hs_seen  <= next_hs_seen;
            fs_count <= next_fs_count;
        end
    end

    // ******************************
    // status word
    // ******************************
    always_comb begin
        status_word                                 = 32'h0;
        status_word[ucc_pkg::ST_POWER_BIT]          = line_ctl.power_switch_on;
        status_word[ucc_pkg::ST_DISCH_BIT]          = line_ctl.discharge_on;
        status_word[ucc_pkg::ST_DATA_SW_BIT]        = line_ctl.data_switch_on;
        status_word[ucc_pkg::ST_SCHEME_LSB +: 3]    = line_ctl.scheme;
        status_word[ucc_pkg::ST_LS_HID_BIT]         = ls_hid;
        status_word[ucc_pkg::ST_FS_HID_BIT]         = fs_hid;
        status_word[ucc_pkg::ST_HS_SEEN_BIT]        = hs_seen;
        status_word[ucc_pkg::ST_OVERRIDE_BIT]       = override;
        status_word[ucc_pkg::ST_STATE_LSB +: 11]    = state;
    end

    // hsize is always a word here and needs no check
    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:5]};

endmodule : ucc_charge_ctrl

`default_nettype wire

//--- logic/ucc_pkg.sv
// constants, types and register map of the usb charge mode controller
package ucc_pkg;

    // ******************************
    // register map
    // ******************************
    localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

    // status field positions
    localparam int ST_POWER_BIT    = 0;
    localparam int ST_DISCH_BIT    = 1;
    localparam int ST_DATA_SW_BIT  = 2;
    localparam int ST_SCHEME_LSB   = 4;
    localparam int ST_LS_HID_BIT   = 8;
    localparam int ST_FS_HID_BIT   = 9;
    localparam int ST_HS_SEEN_BIT  = 10;
    localparam int ST_OVERRIDE_BIT = 11;
    localparam int ST_STATE_LSB    = 16;

    // ******************************
    // timing
    // ******************************
    localparam longint CLK_HZ            = 10_000_000;
    localparam longint DISCHARGE_TIME_MS = 100;
    localparam longint PULLUP_TIME_MS    = 50;
    localparam longint HC_WINDOW_MS      = 20;
    localparam longint FS_QUALIFY_S      = 60;
    localparam int unsigned DISCHARGE_CYCLES =
        int'((DISCHARGE_TIME_MS * CLK_HZ + 999) / 1000);
    localparam int unsigned PULLUP_CYCLES =
        int'((PULLUP_TIME_MS * CLK_HZ + 999) / 1000);
    localparam int unsigned HC_WINDOW_CYCLES =
        int'((HC_WINDOW_MS * CLK_HZ + 999) / 1000);
    localparam int unsigned FS_QUALIFY_CYCLES = int'(FS_QUALIFY_S * CLK_HZ);

    // ******************************
    // types
    // ******************************
    typedef enum logic [2:0] {
        M_OFF, M_AUTO, M_STD_A, M_FORCE_SHORT, M_FORCE_DIV, M_STD_B, M_CHG_PORT
    } ucc_mode_t;

    typedef enum logic [2:0] {
        SCH_OPEN, SCH_DIV_LOW, SCH_DIV_HIGH, SCH_PULLUP, SCH_SHORT
    } ucc_scheme_t;

    typedef enum logic [10:0] {
        S_INIT        = 11'b000_0000_0001,
        S_OFF         = 11'b000_0000_0010,
        S_DISCH       = 11'b000_0000_0100,
        S_DIV_LOW     = 11'b000_0000_1000,
        S_DIV_HIGH    = 11'b000_0001_0000,
        S_PULLUP      = 11'b000_0010_0000,
        S_AUTO_SHORT  = 11'b000_0100_0000,
        S_FORCE_SHORT = 11'b000_1000_0000,
        S_FORCE_DIV   = 11'b001_0000_0000,
        S_STD_PORT    = 11'b010_0000_0000,
        S_CHG_PORT    = 11'b100_0000_0000
    } ucc_state_t;

    // control register, bit 0 is mode_select_1
    typedef struct packed {
        logic enable;
        logic current_limit_select;
        logic mode_select_3;
        logic mode_select_2;
        logic mode_select_1;
    } ucc_ctrl_t;

    // digitised line and load sensing
    typedef struct packed {
        logic dp_high;
        logic dm_high;
        logic high_current;
        logic bc_device_seen;
        logic data_released;
    } ucc_sense_t;

    // drive to switches and signature generator
    typedef struct packed {
        logic        power_switch_on;
        logic        discharge_on;
        logic        data_switch_on;
        ucc_scheme_t scheme;
    } ucc_line_ctl_t;

endpackage : ucc_pkg

//--- tb/ucc_charge_ctrl_props.sv
// checker of the charge controller line drive
`timescale 1ns/1ps
`default_nettype none
module ucc_charge_ctrl_props #(parameter int unsigned DISCHARGE_CYCLES = 4) (
    // clock and resets
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic                   power_on_reset,
    // register bus, to follow control writes
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic [31:0]            hwdata,
    input wire logic                   hready,
    input wire ucc_pkg::ucc_sense_t    sense,
    input wire ucc_pkg::ucc_line_ctl_t line_ctl
);
    // short views of the drive bits
    wire logic       dis = line_ctl.discharge_on;
    wire logic       pwr = line_ctl.power_switch_on;
    wire logic       sw  = line_ctl.data_switch_on;
    wire logic [2:0] sch = line_ctl.scheme;
    // forced divider mode shadowed from the last control write
    logic wr_ctrl;
    logic forced_div;
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ctrl    <= 1'b0;
            forced_div <= 1'b0;
        end else begin
            wr_ctrl <= hsel && htrans[1] && hready && hwrite && haddr == ucc_pkg::ADDR_CTRL;
            if (wr_ctrl) begin
                forced_div <= (hwdata[2:0] == 3'h5);
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_SW_DISCH: assert property (dis |-> !sw)
        else $error("data switch closed during discharge");
    AST_DIS_PWR: assert property (dis |-> !pwr)
        else $error("power on during discharge");
    AST_SW_OPEN: assert property (sw |-> sch == 3'h0)
        else $error("data switch closed with a signature applied");
    AST_POR: assert property (power_on_reset |=> dis && !pwr && sch == 3'h0)
        else $error("power-on reset not held in discharge");
    AST_DIS_END: assert property ($fell(dis) |-> pwr && $past(dis, DISCHARGE_CYCLES))
        else $error("discharge too short or power not restored");
    AST_PULLUP: assert property ($rose(sch == 3'h3) |-> (sch == 3'h3)[*3] ##1 sch == 3'h4)
        else $error("pull-up phase length wrong");
    AST_HIGH: assert property ($rose(sch == 3'h2) |-> $past(sense.high_current))
        else $error("divider high without high current");
    AST_BC: assert property (sch == 3'h1 && !forced_div && sense.bc_device_seen |=> dis)
        else $error("charging device seen without discharge");
endmodule : ucc_charge_ctrl_props
bind ucc_charge_ctrl ucc_charge_ctrl_props #(.DISCHARGE_CYCLES(DISCHARGE_CYCLES)) u_props (
    .clk(clk), .reset(reset), .power_on_reset(power_on_reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .sense(sense),
    .line_ctl(line_ctl));
`default_nettype wire

//--- tb/ucc_dev_model.sv
// portable device model on the charging port
`timescale 1ns/1ps
`default_nettype none
module ucc_dev_model (
    // clock and wanted behaviour
    input wire logic                   clk,
    input wire ucc_pkg::ucc_sense_t    want,
    // controller drive and sensed lines
    input wire ucc_pkg::ucc_line_ctl_t line_ctl,
    output var ucc_pkg::ucc_sense_t    sense
);
    // lines seen only through closed switch, load only with power on
    always @(posedge clk) begin
        sense.dp_high        <= want.dp_high & line_ctl.data_switch_on;
        sense.dm_high        <= want.dm_high & line_ctl.data_switch_on;
        sense.high_current   <= want.high_current & line_ctl.power_switch_on;
        sense.bc_device_seen <= want.bc_device_seen & (line_ctl.scheme inside
            {ucc_pkg::SCH_DIV_LOW, ucc_pkg::SCH_DIV_HIGH});
        sense.data_released  <= want.data_released;
    end
endmodule : ucc_dev_model
`default_nettype wire

//--- tb/ucc_charge_ctrl_tb.sv
// self-checking bench of the charge controller
`timescale 1ns/1ps
`default_nettype none
module ucc_charge_ctrl_tb;
    logic clk = 1'b0, reset = 1'b1, por = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    ucc_pkg::ucc_sense_t want = '0, sense;
    ucc_pkg::ucc_line_ctl_t line_ctl;
    int failures = 0, n_tests = 0;
    // rows: ctrl, state one-hot, scheme, data switch
    logic [19:0] rows [10] = '{20'h80020, 20'ha0082, 20'hb0082, 20'h92001, 20'h9a001,
        20'h88808, 20'ha9002, 20'hba001, 20'hfc001, 20'h3a000};
    always #50 clk = ~clk;
    ucc_charge_ctrl #(.DISCHARGE_CYCLES(4), .PULLUP_CYCLES(3), .HC_WINDOW_CYCLES(5),
        .FS_QUALIFY_CYCLES(10)) u_ucc_charge_ctrl (.clk(clk), .reset(reset),
        .power_on_reset(por), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sense(sense), .line_ctl(line_ctl));
    ucc_dev_model u_ucc_dev_model (.clk(clk), .want(want), .line_ctl(line_ctl), .sense(sense));
    // one single transfer, entered just after a rising edge
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // status read under a mask and compare
    task st(input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, ucc_pkg::ADDR_STATUS, 32'h0);
        n_tests++;
        if ({hresp, rd & m} !== {1'b0, e}) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {hresp, rd & m}, {1'b0, e});
        end
    endtask : st
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    // watchdog
    initial begin
        wt(5000);
        failures++;
        end_sim();
    end
    initial begin
        wt(4);
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            ahb(1'b1, ucc_pkg::ADDR_CTRL, {27'h0, rows[i][19:15]});
            wt(12);
            st(32'h07ff_0074, {5'h0, rows[i][14:4], 9'h0, rows[i][3:1], 1'b0, rows[i][0], 2'h0});
        end
        $display("decode test done");
        por <= 1'b1;
        wt(2);
        st(32'h07ff_0007, 32'h0001_0002);
        por <= 1'b0;
        wt(12);
        st(32'h07ff_0000, 32'h0200_0000);
        $display("power-on test done");
        ahb(1'b1, ucc_pkg::ADDR_CTRL, 32'h14);
        wt(12);
        want.high_current <= 1'b1;
        wt(3);
        st(32'h70, 32'h20);
        wt(8);
        st(32'h70, 32'h20);
        want.high_current <= 1'b0;
        wt(8);
        st(32'h70, 32'h10);
        want.bc_device_seen <= 1'b1;
        wt(2);
        want.bc_device_seen <= 1'b0;
        wt(12);
        st(32'h70, 32'h40);
        wt(5);
        st(32'h70, 32'h40);
        want.data_released <= 1'b1;
        wt(3);
        st(32'h70, 32'h10);
        want.data_released <= 1'b0;
        $display("auto test done");
        ahb(1'b1, ucc_pkg::ADDR_CTRL, 32'h12);
        wt(12);
        want.dm_high <= 1'b1;
        wt(4);
        st(32'h100, 32'h100);
        ahb(1'b1, ucc_pkg::ADDR_CTRL, 32'h16);
        wt(12);
        st(32'h07ff_0800, 32'h0200_0800);
        want.dm_high <= 1'b0;
        wt(16);
        st(32'h07ff_0000, 32'h0008_0000);
        ahb(1'b1, ucc_pkg::ADDR_CTRL, 32'h12);
        wt(12);
        want.dp_high <= 1'b1;
        wt(16);
        st(32'h600, 32'h200);
        want.dp_high <= 1'b0;
        wt(3);
        want.dp_high <= 1'b1;
        wt(3);
        want.dp_high <= 1'b0;
        wt(3);
        want.dp_high <= 1'b1;
        wt(16);
        st(32'h600, 32'h400);
        want.dp_high <= 1'b0;
        $display("wake test done");
        end_sim();
    end
endmodule : ucc_charge_ctrl_tb
`default_nettype wire
